// >>> rtl/ccr_pkg.sv
package ccr_pkg;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int CNT_W  = 5;

   // Register offsets on the serial control port
   localparam logic [14:0] OFF_REF_SEL = 15'h0038;
   localparam logic [14:0] OFF_TS_CTRL = 15'h003B;
   localparam logic [14:0] OFF_SWING   = 15'h0048;
   localparam logic [14:0] OFF_ROUTING = 15'h0060;
   localparam logic [14:0] OFF_CAL_EN  = 15'h0061;

   // Reset values, and the value read at unmapped offsets
   localparam logic [7:0] RST_REF_SEL = 8'h00;
   localparam logic [7:0] RST_TS_CTRL = 8'h00;
   localparam logic [7:0] RST_SWING   = 8'h00;
   localparam logic [7:0] RST_ROUTING = 8'h01;
   localparam logic [7:0] RST_CAL_EN  = 8'h01;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // Field positions
   localparam int BIT_REF_CORE  = 0;
   localparam int BIT_TS_RECV   = 0;
   localparam int BIT_TS_DC     = 1;
   localparam int SWING_LSB     = 0;
   localparam int BIT_SWAP      = 4;
   localparam int SINGLE_LSB    = 0;
   localparam int BIT_CAL_RUN   = 0;
   localparam int HDR_READ_BIT  = 15;

   // Frame: 1 read flag, 15 address bits, 8 data bits, MSB first
   localparam logic [4:0] HEAD_LAST = 5'h0F;
   localparam logic [4:0] BODY_LAST = 5'h17;

   typedef enum logic [1:0] {
      SWING_HIGH = 2'h0,
      SWING_LOW  = 2'h1,
      SWING_RSVD = 2'h2,
      SWING_HIZ  = 2'h3
   } ccr_swing_e;

   typedef enum logic [1:0] {
      SINGLE_RSVD0 = 2'h0,
      SINGLE_A     = 2'h1,
      SINGLE_B     = 2'h2,
      SINGLE_RSVD3 = 2'h3
   } ccr_single_e;

   typedef enum logic [2:0] {
      SP_IDLE = 3'h1,
      SP_HEAD = 3'h2,
      SP_BODY = 3'h4
   } ccr_spi_e;

   typedef struct packed {
      logic       refCoreSupply;
      logic       tsRecvEn;
      logic       tsDcCoupled;
      logic [1:0] swing;
      logic       chanASrcB;
      logic       chanBSrcB;
      logic       calRun;
      logic       calHoldReset;
      logic       dividerReset;
   } ccr_cfg_s;
endpackage

// >>> rtl/ccr_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - Reference select bit 0 set makes the core supply the voltage reference.
// - Timestamp control bit 0 enables the timestamp receiver; clear keeps it off.
// - Timestamp control bit 1 selects DC-coupled low-voltage PECL receiver mode.
// - Swing field codes: 0 high swing, 1 low swing, 3 high-impedance low swing.
// - Dual-channel mode: routing bit 4 swaps inputs A and B.
// - Interleaved mode: single field 1 picks A, 2 picks B; other codes pick A.
// - Input routing register resets to 0x01.
// - Calibration enable high runs calibration; low holds it in reset.
// - Calibration enable register resets to 0x01.
// - Clearing calibration enable also resets the output clock dividers.
module ccr_regs
   import ccr_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic clkEn,
   input  wire logic spiCsN,
   input  wire logic spiSclk,
   input  wire logic spiSdi,
   input  wire logic interleaveEn,
   output logic      spiSdo,
   output logic      spiSdoOe,
   output ccr_cfg_s  cfg
);

   ccr_spi_e          stateQ,   stateD;
   logic [CNT_W-1:0]  cntQ,     cntD;
   logic [14:0]       shiftQ,   shiftD;
   logic [ADDR_W-1:0] addrQ,    addrD;
   logic              isReadQ,  isReadD;
   logic [7:0]        rdShiftQ, rdShiftD;
   logic              sclkQ,    sclkD;
   logic              sdoD,     sdoOeD;
   logic [7:0]        refSelQ,  refSelD;
   logic [7:0]        tsCtrlQ,  tsCtrlD;
   logic [7:0]        swingQ,   swingD;
   logic [7:0]        routingQ, routingD;
   logic [7:0]        calEnQ,   calEnD;
   ccr_cfg_s          cfgD;
   logic              sclkRise;
   logic              sclkFall;
   logic              commitWr;
   logic [7:0]        wrData;
   logic [15:0]       header;

   function automatic logic [7:0] readMux(input logic [ADDR_W-1:0] a,
                                          input logic [7:0] r0,
                                          input logic [7:0] r1,
                                          input logic [7:0] r2,
                                          input logic [7:0] r3,
                                          input logic [7:0] r4);
      logic [7:0] v;
      v = RD_UNMAPPED;
      unique case (a)
         OFF_REF_SEL: v = r0;
         OFF_TS_CTRL: v = r1;
         OFF_SWING:   v = r2;
         OFF_ROUTING: v = r3;
         OFF_CAL_EN:  v = r4;
         default:     v = RD_UNMAPPED;
      endcase
      return v;
   endfunction

   assign sclkRise = spiSclk & ~sclkQ;
   assign sclkFall = ~spiSclk & sclkQ;
   assign wrData   = {shiftQ[6:0], spiSdi};
   assign header   = {shiftQ, spiSdi};

   // Serial port: sample on rising edge, drive read data on falling edge
   always_comb begin
      stateD   = stateQ;
      cntD     = cntQ;
      shiftD   = shiftQ;
      addrD    = addrQ;
      isReadD  = isReadQ;
      rdShiftD = rdShiftQ;
      sclkD    = spiSclk;
      sdoD     = spiSdo;
      sdoOeD   = spiSdoOe;
      commitWr = 1'b0;
      if (spiCsN) begin
         stateD = SP_IDLE;
         cntD   = '0;
         sdoOeD = 1'b0;
      end else begin
         unique case (stateQ)
            SP_IDLE: begin
               stateD = SP_HEAD;
               cntD   = '0;
            end
            SP_HEAD: begin
               if (sclkRise) begin
                  shiftD = header[14:0];
                  cntD   = cntQ + 5'h01;
                  if (cntQ == HEAD_LAST) begin
                     stateD   = SP_BODY;
                     isReadD  = header[HDR_READ_BIT];
                     addrD    = header[14:0];
                     rdShiftD = readMux(header[14:0], refSelQ, tsCtrlQ,
                                        swingQ, routingQ, calEnQ);
                     sdoOeD   = header[HDR_READ_BIT];
                  end
               end
            end
            SP_BODY: begin
               if (sclkRise) begin
                  shiftD = header[14:0];
                  cntD   = cntQ + 5'h01;
                  if (cntQ == BODY_LAST) begin
                     // Further clocks under one select start a new frame
                     stateD   = SP_HEAD;
                     cntD     = '0;
                     sdoOeD   = 1'b0;
                     commitWr = ~isReadQ;
                  end
               end else if (sclkFall && isReadQ) begin
                  sdoD     = rdShiftQ[7];
                  rdShiftD = {rdShiftQ[6:0], 1'b0};
               end
            end
         endcase
      end
   end

   // Registers keep all eight bits, reserved ones included
   always_comb begin
      refSelD  = refSelQ;
      tsCtrlD  = tsCtrlQ;
      swingD   = swingQ;
      routingD = routingQ;
      calEnD   = calEnQ;
      if (commitWr) begin
         unique case (addrQ)
            OFF_REF_SEL: refSelD  = wrData;
            OFF_TS_CTRL: tsCtrlD  = wrData;
            OFF_SWING:   swingD   = wrData;
            OFF_ROUTING: routingD = wrData;
            OFF_CAL_EN:  calEnD   = wrData;
            default:     ;
         endcase
      end
   end

   // Controls follow the new register values in the same edge
   always_comb begin
      cfgD.refCoreSupply = refSelD[BIT_REF_CORE];
      cfgD.tsRecvEn      = tsCtrlD[BIT_TS_RECV];
      cfgD.tsDcCoupled   = tsCtrlD[BIT_TS_DC];
      // Code 2 is passed on as is; avoiding it is the writer's duty
      cfgD.swing         = swingD[SWING_LSB +: 2];
      if (interleaveEn) begin
         // Reserved codes fall back to input A
         cfgD.chanASrcB = (routingD[SINGLE_LSB +: 2] == SINGLE_B);
         cfgD.chanBSrcB = (routingD[SINGLE_LSB +: 2] == SINGLE_B);
      end else begin
         cfgD.chanASrcB = routingD[BIT_SWAP];
         cfgD.chanBSrcB = ~routingD[BIT_SWAP];
      end
      cfgD.calRun        = calEnD[BIT_CAL_RUN];
      cfgD.calHoldReset  = ~calEnD[BIT_CAL_RUN];
      cfgD.dividerReset  = ~calEnD[BIT_CAL_RUN];
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         stateQ   <= SP_IDLE;
         cntQ     <= '0;
         shiftQ   <= '0;
         addrQ    <= '0;
         isReadQ  <= 1'b0;
         rdShiftQ <= '0;
         sclkQ    <= 1'b0;
         spiSdo   <= 1'b0;
         spiSdoOe <= 1'b0;
         refSelQ  <= RST_REF_SEL;
         tsCtrlQ  <= RST_TS_CTRL;
         swingQ   <= RST_SWING;
         routingQ <= RST_ROUTING;
         calEnQ   <= RST_CAL_EN;
         cfg      <= '{refCoreSupply: 1'b0, tsRecvEn: 1'b0,
                       tsDcCoupled: 1'b0, swing: SWING_HIGH,
                       chanASrcB: 1'b0, chanBSrcB: 1'b1, calRun: 1'b1,
                       calHoldReset: 1'b0, dividerReset: 1'b0};
      end else if (clkEn) begin
         stateQ   <= stateD;
         cntQ     <= cntD;
         shiftQ   <= shiftD;
         addrQ    <= addrD;
         isReadQ  <= isReadD;
         rdShiftQ <= rdShiftD;
         sclkQ    <= sclkD;
         spiSdo   <= sdoD;
         spiSdoOe <= sdoOeD;
         refSelQ  <= refSelD;
         tsCtrlQ  <= tsCtrlD;
         swingQ   <= swingD;
         routingQ <= routingD;
         calEnQ   <= calEnD;
         cfg      <= cfgD;
      end
   end

   // Checks
   sequence s_swingWrite;
      clkEn && commitWr && addrQ == OFF_SWING;
   endsequence

   sequence s_afterReset;
      $past(reset);
   endsequence

   a_ref_core_supply: assert property (@(posedge sys_clk) disable iff (reset)
      cfg.refCoreSupply == refSelQ[BIT_REF_CORE])
      else $error("reference select output differs from register");
   a_ts_receiver_en: assert property (@(posedge sys_clk) disable iff (reset)
      cfg.tsRecvEn == tsCtrlQ[BIT_TS_RECV])
      else $error("timestamp receiver enable differs from register");
   a_ts_dc_mode: assert property (@(posedge sys_clk) disable iff (reset)
      cfg.tsDcCoupled == tsCtrlQ[BIT_TS_DC])
      else $error("timestamp mode differs from register");
   a_swing_write_mode: assert property (@(posedge sys_clk)
      disable iff (reset)
      s_swingWrite |=> cfg.swing == swingQ[SWING_LSB +: 2]
                       && swingQ == $past(wrData))
      else $error("swing write not applied or not stored whole");
   // Reset value of cfg assumes dual-channel routing for one cycle
   a_dual_input_swap: assert property (@(posedge sys_clk) disable iff (reset)
      $past(clkEn) && !$past(reset) && !$past(interleaveEn) |->
         cfg.chanASrcB == routingQ[BIT_SWAP]
         && cfg.chanBSrcB != routingQ[BIT_SWAP])
      else $error("dual-channel routing wrong");
   a_single_input_sel: assert property (@(posedge sys_clk) disable iff (reset)
      $past(clkEn) && !$past(reset) && $past(interleaveEn) |->
         cfg.chanASrcB == cfg.chanBSrcB
         && cfg.chanASrcB == (routingQ[1:0] == SINGLE_B))
      else $error("interleaved input selection wrong");
   a_routing_reset_val: assert property (@(posedge sys_clk)
      disable iff (reset)
      s_afterReset |-> routingQ == RST_ROUTING)
      else $error("routing register reset value wrong");
   a_cal_reset_val: assert property (@(posedge sys_clk) disable iff (reset)
      s_afterReset |-> calEnQ == RST_CAL_EN && cfg.calRun)
      else $error("calibration enable reset value wrong");
   a_cal_hold_run: assert property (@(posedge sys_clk) disable iff (reset)
      cfg.calRun == calEnQ[BIT_CAL_RUN]
      && cfg.calHoldReset == !cfg.calRun)
      else $error("calibration run and hold disagree");
   a_divider_reset: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(cfg.calRun) |-> cfg.dividerReset)
      else $error("dividers not reset when calibration cleared");
endmodule

// >>> sim/ccr_regs_test.sv
`timescale 1ns/1ps
module ccr_regs_test
   import ccr_pkg::*;
;
   logic        sys_clk;
   logic        reset;
   logic        clkEn;
   logic        spiCsN;
   logic        spiSclk;
   logic        spiSdi;
   logic        interleaveEn;
   logic        spiSdo;
   logic        spiSdoOe;
   ccr_cfg_s    cfg;
   int          nErrors;
   int          compares;
   logic [7:0]  rd;
   logic [7:0]  shadow [5];
   logic [14:0] offs [5];

   ccr_regs dut (
      .sys_clk      (sys_clk),
      .reset        (reset),
      .clkEn        (clkEn),
      .spiCsN       (spiCsN),
      .spiSclk      (spiSclk),
      .spiSdi       (spiSdi),
      .interleaveEn (interleaveEn),
      .spiSdo       (spiSdo),
      .spiSdoOe     (spiSdoOe),
      .cfg          (cfg)
   );

   always #12.5 sys_clk = ~sys_clk;

   task automatic tally_and_finish;
      $display("errors=%0d compares=%0d", nErrors, compares);
      if (nErrors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      compares++;
      if (seen !== exp) begin
         nErrors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Reference model of the register fields driving the config outputs
   function automatic ccr_cfg_s exp_cfg();
      logic a;
      logic b;
      if (interleaveEn) begin
         a = (shadow[3][1:0] == 2'h2);
         b = a;
      end else begin
         a = shadow[3][4];
         b = ~shadow[3][4];
      end
      return ccr_cfg_s'{shadow[0][0], shadow[1][0], shadow[1][1],
                        shadow[2][1:0], a, b, shadow[4][0],
                        ~shadow[4][0], ~shadow[4][0]};
   endfunction

   task automatic init_shadow;
      shadow = '{RST_REF_SEL, RST_TS_CTRL, RST_SWING, RST_ROUTING,
                 RST_CAL_EN};
   endtask

   // Four sys_clk cycles per serial clock level keeps margin over the
   // one-cycle minimum; nb below 24 aborts the frame early
   task automatic xfer(input logic rdf, input logic [14:0] ad,
                       input logic [7:0] wd, input int nb,
                       output logic [7:0] rdat);
      logic [23:0] fr;
      fr = {rdf, ad, wd};
      rdat = 8'h00;
      @(posedge sys_clk);
      spiCsN <= 1'b0;
      repeat (3) @(posedge sys_clk);
      for (int i = 23; i >= 24 - nb; i--) begin
         spiSdi <= fr[i];
         repeat (4) @(posedge sys_clk);
         if (i < 8) begin
            rdat[i] = spiSdo;
            check(10'(spiSdoOe), 10'(rdf));
         end
         spiSclk <= 1'b1;
         repeat (4) @(posedge sys_clk);
         spiSclk <= 1'b0;
      end
      repeat (4) @(posedge sys_clk);
      spiCsN <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check(10'(spiSdoOe), 10'h000);
   endtask

   task automatic wr(input int k, input logic [7:0] d);
      xfer(1'b0, offs[k], d, 24, rd);
      shadow[k] = d;
   endtask

   task automatic rdchk(input int k);
      xfer(1'b1, offs[k], 8'h00, 24, rd);
      check(10'(rd), 10'(shadow[k]));
      check(cfg, exp_cfg());
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      nErrors++;
      tally_and_finish;
   end

   initial begin
      logic [7:0] rtab [7];
      sys_clk = 1'b0;
      reset = 1'b1;
      clkEn = 1'b1;
      spiCsN = 1'b1;
      spiSclk = 1'b0;
      spiSdi = 1'b0;
      interleaveEn = 1'b0;
      offs = '{OFF_REF_SEL, OFF_TS_CTRL, OFF_SWING, OFF_ROUTING, OFF_CAL_EN};
      rtab = '{8'h00, 8'h10, 8'h01, 8'h02, 8'h03, 8'h12, 8'hE1};
      init_shadow();
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      check(cfg, exp_cfg());
      for (int k = 0; k < 5; k++)
         rdchk(k);
      wr(0, 8'hFF);
      rdchk(0);
      wr(0, 8'h00);
      rdchk(0);
      for (int v = 0; v < 4; v++) begin
         wr(1, 8'hA4 | 8'(v));
         rdchk(1);
      end
      // Code 2 is reserved and never written; code 3 assumes short lines
      for (int v = 0; v < 4; v++) begin
         if (v != 2) begin
            wr(2, {6'h2A, 2'(v)});
            rdchk(2);
         end
      end
      for (int m = 0; m < 2; m++) begin
         interleaveEn <= m[0];
         for (int j = 0; j < 7; j++) begin
            wr(3, rtab[j]);
            rdchk(3);
         end
      end
      // No link enable here, so it is taken as off around these writes
      wr(4, 8'hFE);
      rdchk(4);
      wr(4, 8'h01);
      rdchk(4);
      xfer(1'b0, 15'h0039, 8'h5A, 24, rd);
      xfer(1'b1, 15'h0039, 8'h00, 24, rd);
      check(10'(rd), 10'(RD_UNMAPPED));
      xfer(1'b0, OFF_SWING, 8'h01, 20, rd);
      rdchk(2);
      // A frozen clock enable must swallow a whole frame
      clkEn <= 1'b0;
      xfer(1'b0, OFF_SWING, 8'h03, 24, rd);
      clkEn <= 1'b1;
      rdchk(2);
      wr(4, 8'h00);
      @(posedge sys_clk);
      reset <= 1'b1;
      @(posedge sys_clk);
      reset <= 1'b0;
      init_shadow();
      for (int k = 0; k < 5; k++)
         rdchk(k);
      tally_and_finish;
   end
endmodule
